/* File: rtl/pec_host_ctrl.sv */
// Serial programmer controller: command framing, waits and checksum
// Function
// - Checksum is sixteen-bit sum, carries dropped
// - Unprotected: sum program words, then masked config
// - Protected: sum only masked config and IDs
// - Mask and end address chosen by variant
// - Pack ID low nibbles, first ID highest
// - Data bytes imaged from 0x2100 upward
// - At least 1 us between frames
// - Wait 3 or 6 ms after internal program
// - Hold external program cycle 3 ms
// - Wait 100 us discharge before reading
// - Image carries config and IDs by default
`timescale 1ns/1ps
`default_nettype none
`include "pec_consts.svh"

module pec_host_ctrl #(
  parameter int INT_PM_WAIT_CYC = `PEC_PROG_PM_CYC,
  parameter int INT_DM_WAIT_CYC = `PEC_PROG_DM_CYC,
  parameter int EXT_PM_WAIT_CYC = `PEC_EXT_PM_CYC,
  parameter int DISCH_WAIT_CYC  = `PEC_DISCH_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  output var  logic              req_ready,
  input  wire logic [5:0]        req_cmd,
  input  wire logic              req_data_en,
  input  wire logic              req_read,
  input  wire logic [13:0]       req_wdata,
  input  wire pec_pkg::pec_wait_t req_wait,
  output var  logic              rsp_valid,
  output var  logic [13:0]       rsp_rdata,
  output var  logic              icsp_clk,
  output var  logic              icsp_dat_o,
  output var  logic              icsp_dat_oe,
  input  wire logic              icsp_dat_i,
  input  wire logic              cks_start,
  input  wire logic [1:0]        cks_size,
  input  wire logic              cks_wide_mask,
  input  wire logic              cks_code_protect_n,
  input  wire logic [13:0]       cks_cfg,
  input  wire logic [13:0]       cks_id0,
  input  wire logic [13:0]       cks_id1,
  input  wire logic [13:0]       cks_id2,
  input  wire logic [13:0]       cks_id3,
  input  wire logic              cks_word_valid,
  input  wire logic [12:0]       cks_word_addr,
  input  wire logic [13:0]       cks_word_data,
  input  wire logic              cks_finish,
  output var  logic              cks_busy,
  output var  logic              cks_done,
  output var  logic [15:0]       cks_value,
  input  wire logic [7:0]        dm_index,
  output var  logic [15:0]       dm_img_addr,
  input  wire logic              img_omit_cfg,
  output var  logic              img_emit_cfg
);

  localparam logic [3:0]  HALF_M1 = 4'(`PEC_HALF_BIT_CYC - 1);
  localparam logic [19:0] GAP_M1  = 20'(`PEC_CMD_GAP_CYC - 1);
  localparam int          GAP_CYC = `PEC_CMD_GAP_CYC;

  pec_pkg::pec_ctrl_t ctrl_reg;
  pec_pkg::pec_ctrl_t ctrl_next;
  logic [4:0]         last_bit;

  // ==========================================================
  // Next-state logic
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.rsp_valid = 1'h0;
    ctrl_next.clr = 1'h0;
    ctrl_next.add_v = 1'h0;
    ctrl_next.fin_pend = 1'h0;
    ctrl_next.cks_done = ctrl_reg.fin_pend;
    last_bit = ctrl_reg.in_data ? `PEC_FRAME_LAST : `PEC_CMD_LAST;
    // Data pin synchroniser, change taken when stages two and three agree
    ctrl_next.s1 = icsp_dat_i;
    ctrl_next.s2 = ctrl_reg.s1;
    ctrl_next.s3 = ctrl_reg.s2;
    if (ctrl_reg.s2 == ctrl_reg.s3) begin
      ctrl_next.dat_f = ctrl_reg.s3;
    end
    // Image placement of a data byte
    ctrl_next.dm_img_addr = `PEC_DM_IMG_BASE + {8'h00, dm_index};
    // Config and IDs saved unless told otherwise
    ctrl_next.img_emit = ~img_omit_cfg;

    // Serial engine
    case (ctrl_reg.st)
      pec_pkg::PEC_IDLE: begin
        if (req_valid && ctrl_reg.req_ready) begin
          ctrl_next.req_ready = 1'h0;
          ctrl_next.shreg = {10'h000, req_cmd};
          ctrl_next.has_data = req_data_en;
          ctrl_next.rd = req_read;
          ctrl_next.wdat = req_wdata;
          ctrl_next.wait_kind = req_wait;
          ctrl_next.in_data = 1'h0;
          ctrl_next.bit_cnt = 5'h00;
          ctrl_next.clk_o = 1'h1;
          ctrl_next.dat_o = req_cmd[0];
          ctrl_next.dat_oe = 1'h1;
          ctrl_next.half = HALF_M1;
          ctrl_next.st = pec_pkg::PEC_SHIFT;
        end else begin
          ctrl_next.req_ready = 1'h1;  // Ready rises on the first idle cycle after reset
        end
      end
      pec_pkg::PEC_SHIFT: begin
        if (ctrl_reg.half != 4'h0) begin
          ctrl_next.half = ctrl_reg.half - 4'h1;
        end else if (ctrl_reg.clk_o) begin
          // Falling edge, read bit sampled here
          ctrl_next.clk_o = 1'h0;
          ctrl_next.half = HALF_M1;
          ctrl_next.shreg = {(ctrl_reg.rd && ctrl_reg.in_data) ? ctrl_reg.dat_f : 1'h0,
                             ctrl_reg.shreg[15:1]};
        end else if (ctrl_reg.bit_cnt == last_bit) begin
          ctrl_next.st = pec_pkg::PEC_GAP;
          ctrl_next.cnt = GAP_M1;
          if (ctrl_reg.has_data && !ctrl_reg.in_data && ctrl_reg.rd) begin
            ctrl_next.dat_oe = 1'h0;
          end
        end else begin
          ctrl_next.bit_cnt = ctrl_reg.bit_cnt + 5'h01;
          ctrl_next.clk_o = 1'h1;
          ctrl_next.dat_o = ctrl_reg.shreg[0];
          ctrl_next.half = HALF_M1;
        end
      end
      pec_pkg::PEC_GAP: begin
        // Clock held low from last fall to next rise
        if (ctrl_reg.cnt != 20'h00000) begin
          ctrl_next.cnt = ctrl_reg.cnt - 20'h00001;
        end else if (ctrl_reg.has_data && !ctrl_reg.in_data) begin
          ctrl_next.in_data = 1'h1;
          ctrl_next.shreg = ctrl_reg.rd ? 16'h0000 : {1'h0, ctrl_reg.wdat, 1'h0};
          ctrl_next.bit_cnt = 5'h00;
          ctrl_next.clk_o = 1'h1;
          ctrl_next.dat_o = 1'h0;
          ctrl_next.half = HALF_M1;
          ctrl_next.st = pec_pkg::PEC_SHIFT;
        end else begin
          ctrl_next.dat_oe = 1'h1;
          ctrl_next.dat_o = 1'h0;
          if (ctrl_reg.rd) begin
            // Protected program words come back as zeros here
            ctrl_next.rsp_valid = 1'h1;
            ctrl_next.rdata = ctrl_reg.shreg[14:1];
          end
          case (ctrl_reg.wait_kind)
            pec_pkg::PEC_W_INT_PM: begin
              ctrl_next.st = pec_pkg::PEC_WAIT;
              ctrl_next.cnt = 20'(INT_PM_WAIT_CYC - 1);
            end
            pec_pkg::PEC_W_INT_DM: begin
              // Also covers bulk erase, which may clear data memory too
              ctrl_next.st = pec_pkg::PEC_WAIT;
              ctrl_next.cnt = 20'(INT_DM_WAIT_CYC - 1);
            end
            pec_pkg::PEC_W_EXT_PM: begin
              ctrl_next.st = pec_pkg::PEC_WAIT;
              ctrl_next.cnt = 20'(EXT_PM_WAIT_CYC - 1);
            end
            pec_pkg::PEC_W_DISCH: begin
              ctrl_next.st = pec_pkg::PEC_DISCH;
              ctrl_next.cnt = 20'(DISCH_WAIT_CYC - 1);
            end
            default: begin
              ctrl_next.st = pec_pkg::PEC_IDLE;
              ctrl_next.req_ready = 1'h1;
            end
          endcase
        end
      end
      pec_pkg::PEC_WAIT: begin
        if (ctrl_reg.cnt != 20'h00000) begin
          ctrl_next.cnt = ctrl_reg.cnt - 20'h00001;
        end else if (ctrl_reg.wait_kind == pec_pkg::PEC_W_EXT_PM) begin
          // Caller now sends the end-programming command
          ctrl_next.st = pec_pkg::PEC_IDLE;
          ctrl_next.req_ready = 1'h1;
        end else begin
          ctrl_next.st = pec_pkg::PEC_DISCH;
          ctrl_next.cnt = 20'(DISCH_WAIT_CYC - 1);
        end
      end
      pec_pkg::PEC_DISCH: begin
        if (ctrl_reg.cnt != 20'h00000) begin
          ctrl_next.cnt = ctrl_reg.cnt - 20'h00001;
        end else begin
          ctrl_next.st = pec_pkg::PEC_IDLE;
          ctrl_next.req_ready = 1'h1;
        end
      end
      default: begin
        ctrl_next.st = pec_pkg::PEC_IDLE;
        ctrl_next.req_ready = 1'h1;
      end
    endcase

    // Checksum sequencer, config and IDs taken from the loaded image
    case (ctrl_reg.ck_st)
      pec_pkg::PEC_CK_IDLE: begin
        if (cks_start) begin
          ctrl_next.clr = 1'h1;
          ctrl_next.prot = ~cks_code_protect_n;
          if (cks_size == 2'h0) begin
            ctrl_next.end_addr = `PEC_END_1K;
          end else if (cks_size == 2'h1) begin
            ctrl_next.end_addr = `PEC_END_2K;
          end else begin
            ctrl_next.end_addr = `PEC_END_4K;
          end
          ctrl_next.cfgm = {2'h0, cks_cfg & (cks_wide_mask ? `PEC_CFG_MASK_W
                                                          : `PEC_CFG_MASK_N)};
          ctrl_next.idp = {cks_id0[3:0], cks_id1[3:0], cks_id2[3:0], cks_id3[3:0]};
          ctrl_next.ck_st = pec_pkg::PEC_CK_RUN;
        end
      end
      pec_pkg::PEC_CK_RUN: begin
        if (cks_finish) begin
          ctrl_next.ck_st = pec_pkg::PEC_CK_CFG;
        end else if (cks_word_valid && !ctrl_reg.prot &&
                     cks_word_addr <= ctrl_reg.end_addr) begin
          ctrl_next.add_v = 1'h1;
          ctrl_next.add_val = {2'h0, cks_word_data};
        end
      end
      pec_pkg::PEC_CK_CFG: begin
        ctrl_next.add_v = 1'h1;
        ctrl_next.add_val = ctrl_reg.cfgm;
        if (ctrl_reg.prot) begin
          ctrl_next.ck_st = pec_pkg::PEC_CK_ID;
        end else begin
          ctrl_next.ck_st = pec_pkg::PEC_CK_IDLE;
          ctrl_next.fin_pend = 1'h1;
        end
      end
      pec_pkg::PEC_CK_ID: begin
        ctrl_next.add_v = 1'h1;
        ctrl_next.add_val = ctrl_reg.idp;
        ctrl_next.ck_st = pec_pkg::PEC_CK_IDLE;
        ctrl_next.fin_pend = 1'h1;
      end
      default: begin
        ctrl_next.ck_st = pec_pkg::PEC_CK_IDLE;
      end
    endcase
    ctrl_next.busy = (ctrl_next.ck_st != pec_pkg::PEC_CK_IDLE);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= '0;
      ctrl_reg.st <= pec_pkg::PEC_IDLE;
      ctrl_reg.ck_st <= pec_pkg::PEC_CK_IDLE;
      ctrl_reg.wait_kind <= pec_pkg::PEC_W_NONE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Accumulator
  pec_cks_acc u_acc (
    .clk       (clk),
    .rst       (rst),
    .clear     (ctrl_reg.clr),
    .add_valid (ctrl_reg.add_v),
    .add_value (ctrl_reg.add_val),
    .sum       (cks_value)
  );

  // Outputs from flops
  assign req_ready    = ctrl_reg.req_ready;
  assign rsp_valid    = ctrl_reg.rsp_valid;
  assign rsp_rdata    = ctrl_reg.rdata;
  assign icsp_clk     = ctrl_reg.clk_o;
  assign icsp_dat_o   = ctrl_reg.dat_o;
  assign icsp_dat_oe  = ctrl_reg.dat_oe;
  assign cks_busy     = ctrl_reg.busy;
  assign cks_done     = ctrl_reg.cks_done;
  assign dm_img_addr  = ctrl_reg.dm_img_addr;
  assign img_emit_cfg = ctrl_reg.img_emit;

  // ==========================================================
  // Checks: cycles spent in the current engine state
  logic [19:0] stay_len;
  always_ff @(posedge clk) begin
    if (rst || ctrl_next.st != ctrl_reg.st) begin
      stay_len <= 20'h00000;
    end else begin
      stay_len <= stay_len + 20'h00001;
    end
  end

  property p_gap;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.st == pec_pkg::PEC_GAP && ctrl_next.st != pec_pkg::PEC_GAP)
      |-> (int'(stay_len) >= GAP_CYC - 1) && !icsp_clk;
  endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");

  property p_int_wait;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.st == pec_pkg::PEC_WAIT && ctrl_next.st != pec_pkg::PEC_WAIT &&
     ctrl_reg.wait_kind != pec_pkg::PEC_W_EXT_PM)
      |-> int'(stay_len) >= ((ctrl_reg.wait_kind == pec_pkg::PEC_W_INT_DM) ?
                             INT_DM_WAIT_CYC : INT_PM_WAIT_CYC) - 1;
  endproperty
  a_int_wait: assert property (p_int_wait) else $error("program wait short");

  property p_ext_wait;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.st == pec_pkg::PEC_WAIT && ctrl_next.st != pec_pkg::PEC_WAIT &&
     ctrl_reg.wait_kind == pec_pkg::PEC_W_EXT_PM)
      |-> int'(stay_len) >= EXT_PM_WAIT_CYC - 1;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("external hold short");

  property p_disch;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.st == pec_pkg::PEC_DISCH && ctrl_next.st != pec_pkg::PEC_DISCH)
      |-> int'(stay_len) >= DISCH_WAIT_CYC - 1 ##1 req_ready;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge wait short");

  property p_prot_skip;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.ck_st == pec_pkg::PEC_CK_RUN && ctrl_reg.prot) |=> !ctrl_reg.add_v;
  endproperty
  a_prot_skip: assert property (p_prot_skip) else $error("protected word summed");

  property p_range;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.ck_st == pec_pkg::PEC_CK_RUN && cks_word_valid && !cks_finish &&
     !ctrl_reg.prot && cks_word_addr > ctrl_reg.end_addr) |=> !ctrl_reg.add_v;
  endproperty
  a_range: assert property (p_range) else $error("word beyond range summed");

  property p_mask;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.ck_st == pec_pkg::PEC_CK_IDLE && cks_start && !cks_wide_mask)
      |=> ##1 (ctrl_reg.cfgm[15:12] == 4'h0) && ctrl_reg.busy;
  endproperty
  a_mask: assert property (p_mask) else $error("config mask wrong");

  property p_ids;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.ck_st == pec_pkg::PEC_CK_IDLE && cks_start)
      |=> ctrl_reg.idp == {$past(cks_id0[3:0]), $past(cks_id1[3:0]),
                           $past(cks_id2[3:0]), $past(cks_id3[3:0])};
  endproperty
  a_ids: assert property (p_ids) else $error("user ID packing wrong");

  property p_start_clear;
    @(posedge clk) disable iff (rst)
    (ctrl_reg.ck_st == pec_pkg::PEC_CK_IDLE && cks_start) |=> ##1 (cks_value == 16'h0000);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("sum not cleared");

  property p_img;
    @(posedge clk) disable iff (rst)
    !rst |=> dm_img_addr == `PEC_DM_IMG_BASE + {8'h00, $past(dm_index)};
  endproperty
  a_img: assert property (p_img) else $error("data image address wrong");

  property p_emit;
    @(posedge clk) disable iff (rst)
    !rst && !img_omit_cfg |=> img_emit_cfg;
  endproperty
  a_emit: assert property (p_emit) else $error("config not emitted");

  c_read:  cover property (@(posedge clk) disable iff (rst) rsp_valid);
  c_prot:  cover property (@(posedge clk) disable iff (rst) cks_done && ctrl_reg.prot);
  c_open:  cover property (@(posedge clk) disable iff (rst) cks_done && !ctrl_reg.prot);
  c_wait:  cover property (@(posedge clk) disable iff (rst)
                           ctrl_reg.st == pec_pkg::PEC_WAIT ##1
                           ctrl_reg.st == pec_pkg::PEC_DISCH);

endmodule // pec_host_ctrl

`default_nettype wire

/* File: rtl/pec_consts.svh */
// Timing, address and mask constants for the serial programmer controller
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

// ==========================================================
// Clock
`define PEC_CLK_PERIOD_NS   10

// ==========================================================
// Serial timing, times in their own units
`define PEC_HALF_BIT_NS     100
`define PEC_CMD_GAP_NS      1000
`define PEC_PROG_PM_MS      3
`define PEC_PROG_DM_MS      6
`define PEC_EXT_PM_MS       3
`define PEC_DISCH_US        100

// ==========================================================
// Derived cycle counts, least times rounded up
`define PEC_HALF_BIT_CYC ((`PEC_HALF_BIT_NS + `PEC_CLK_PERIOD_NS - 1) / `PEC_CLK_PERIOD_NS)
`define PEC_CMD_GAP_CYC  ((`PEC_CMD_GAP_NS + `PEC_CLK_PERIOD_NS - 1) / `PEC_CLK_PERIOD_NS)
`define PEC_PROG_PM_CYC  ((`PEC_PROG_PM_MS * 1000000 + `PEC_CLK_PERIOD_NS - 1) / `PEC_CLK_PERIOD_NS)
`define PEC_PROG_DM_CYC  ((`PEC_PROG_DM_MS * 1000000 + `PEC_CLK_PERIOD_NS - 1) / `PEC_CLK_PERIOD_NS)
`define PEC_EXT_PM_CYC   ((`PEC_EXT_PM_MS * 1000000 + `PEC_CLK_PERIOD_NS - 1) / `PEC_CLK_PERIOD_NS)
`define PEC_DISCH_CYC    ((`PEC_DISCH_US * 1000 + `PEC_CLK_PERIOD_NS - 1) / `PEC_CLK_PERIOD_NS)

// ==========================================================
// Frame lengths, last bit index
`define PEC_CMD_LAST     5'h05
`define PEC_FRAME_LAST   5'h0F

// ==========================================================
// Checksum ranges and masks
`define PEC_END_1K       13'h03FF
`define PEC_END_2K       13'h07FF
`define PEC_END_4K       13'h0FFF
`define PEC_CFG_MASK_N   14'h0FFF
`define PEC_CFG_MASK_W   14'h1FFF

// ==========================================================
// Image placement of data memory
`define PEC_DM_IMG_BASE  16'h2100

`endif

/* File: rtl/pec_pkg.sv */
// Types for the serial programmer controller
package pec_pkg;

  // ==========================================================
  // Serial engine states
  typedef enum logic [4:0] {
    PEC_IDLE  = 5'h01,
    PEC_SHIFT = 5'h02,
    PEC_GAP   = 5'h04,
    PEC_WAIT  = 5'h08,
    PEC_DISCH = 5'h10
  } pec_state_t;

  // ==========================================================
  // Checksum sequencer states
  typedef enum logic [3:0] {
    PEC_CK_IDLE = 4'h1,
    PEC_CK_RUN  = 4'h2,
    PEC_CK_CFG  = 4'h4,
    PEC_CK_ID   = 4'h8
  } pec_ck_state_t;

  // ==========================================================
  // Wait that follows a command
  typedef enum logic [2:0] {
    PEC_W_NONE   = 3'h0,
    PEC_W_INT_PM = 3'h1,
    PEC_W_INT_DM = 3'h2,
    PEC_W_EXT_PM = 3'h3,
    PEC_W_DISCH  = 3'h4
  } pec_wait_t;

  // ==========================================================
  // Whole controller state
  typedef struct packed {
    pec_state_t    st;
    logic [3:0]    half;
    logic [4:0]    bit_cnt;
    logic          in_data;
    logic          has_data;
    logic          rd;
    pec_wait_t     wait_kind;
    logic [13:0]   wdat;
    logic [15:0]   shreg;
    logic [19:0]   cnt;
    logic          clk_o;
    logic          dat_o;
    logic          dat_oe;
    logic          req_ready;
    logic          rsp_valid;
    logic [13:0]   rdata;
    logic          s1;
    logic          s2;
    logic          s3;
    logic          dat_f;
    pec_ck_state_t ck_st;
    logic          prot;
    logic [12:0]   end_addr;
    logic [15:0]   cfgm;
    logic [15:0]   idp;
    logic          clr;
    logic          add_v;
    logic [15:0]   add_val;
    logic          fin_pend;
    logic          cks_done;
    logic          busy;
    logic [15:0]   dm_img_addr;
    logic          img_emit;
  } pec_ctrl_t;

  // ==========================================================
  // Accumulator state
  typedef struct packed {
    logic [15:0] sum;
  } pec_acc_t;

endpackage

/* File: rtl/pec_cks_acc.sv */
// Sixteen-bit wrapping checksum accumulator
`timescale 1ns/1ps
`default_nettype none

module pec_cks_acc (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        add_valid,
  input  wire logic [15:0] add_value,
  output var  logic [15:0] sum
);

  pec_pkg::pec_acc_t acc_reg;
  pec_pkg::pec_acc_t acc_next;

  // ==========================================================
  // Clear or add, carry out of bit 15 dropped
  always_comb begin
    acc_next = acc_reg;
    if (clear) begin
      acc_next.sum = 16'h0000;
    end else if (add_valid) begin
      acc_next.sum = 16'(acc_reg.sum + add_value);
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign sum = acc_reg.sum;

  // ==========================================================
  // Checks
  property p_wrap;
    @(posedge clk) disable iff (rst)
    (add_valid && !clear) |=> (sum == 16'($past(sum) + $past(add_value)));
  endproperty
  a_wrap: assert property (p_wrap) else $error("checksum add wrong");

  property p_clear;
    @(posedge clk) disable iff (rst)
    clear |=> (sum == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("checksum not cleared");

endmodule // pec_cks_acc

`default_nettype wire

/* File: verif/pec_dev_model.sv */
// Target device model answering read frames on the serial data pin
`timescale 1ns/1ps
`default_nettype none

module pec_dev_model #(
  parameter logic [13:0] WORD = 14'h2A5C
) (
  input  wire logic        icsp_clk,
  input  wire logic        icsp_dat_oe,
  input  wire logic        host_dat,
  input  wire logic        code_protect_n,
  output var  logic        dat_out,
  output var  logic [15:0] wr_word
);
  logic [4:0]  idx;
  logic [13:0] rd_word;

  // ==========================================================
  // Read word; protected program memory reads as zeros
  assign rd_word = code_protect_n ? WORD : 14'h0000;

  initial begin
    idx = 5'h00;
    dat_out = 1'b1;
    wr_word = 16'h0000;
  end

  // Host bits taken at clock fall while it drives; last frame ends up here
  always @(negedge icsp_clk) begin
    if (icsp_dat_oe) begin
      wr_word <= {host_dat, wr_word[15:1]};
    end
  end

  // One bit per clock rise while released: start, payload LSB first, stop
  always @(posedge icsp_clk) begin
    if (icsp_dat_oe) begin
      idx <= 5'h00;
      dat_out <= ~dat_out;
    end else begin
      idx <= idx + 5'h01;
      dat_out <= (idx == 5'h00 || idx > 5'h0E) ? 1'b0 : rd_word[idx - 5'h01];
    end
  end
endmodule // pec_dev_model

`default_nettype wire

/* File: verif/pec_host_ctrl_bench.sv */
// Self-checking bench for the serial programmer controller
`timescale 1ns/1ps
`default_nettype none

module pec_host_ctrl_bench;
  logic clk, rst, req_valid, req_ready, req_data_en, req_read, rsp_valid;
  logic [5:0] req_cmd;
  logic [13:0] req_wdata, rsp_rdata, cks_cfg, cks_id0, cks_id1, cks_id2, cks_id3, cks_word_data;
  pec_pkg::pec_wait_t req_wait;
  logic icsp_clk, icsp_dat_o, icsp_dat_oe, pin, dev_out, cks_start, cks_wide_mask;
  logic cks_code_protect_n, cks_word_valid, cks_finish, cks_busy, cks_done, img_omit_cfg;
  logic img_emit_cfg, dev_prot_n;
  logic [1:0] cks_size;
  logic [12:0] cks_word_addr;
  logic [15:0] cks_value, dm_img_addr, v, dev_wr;
  logic [7:0] dm_index;
  int mismatches = 0, samples_checked = 0, lowrun = 0, mingap = 1000, dur;

  pec_host_ctrl #(.INT_PM_WAIT_CYC(20), .INT_DM_WAIT_CYC(30), .EXT_PM_WAIT_CYC(20),
    .DISCH_WAIT_CYC(10)) uut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_data_en(req_data_en), .req_read(req_read),
    .req_wdata(req_wdata), .req_wait(req_wait), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .icsp_clk(icsp_clk), .icsp_dat_o(icsp_dat_o), .icsp_dat_oe(icsp_dat_oe), .icsp_dat_i(pin),
    .cks_start(cks_start), .cks_size(cks_size), .cks_wide_mask(cks_wide_mask),
    .cks_code_protect_n(cks_code_protect_n), .cks_cfg(cks_cfg), .cks_id0(cks_id0),
    .cks_id1(cks_id1), .cks_id2(cks_id2), .cks_id3(cks_id3), .cks_word_valid(cks_word_valid),
    .cks_word_addr(cks_word_addr), .cks_word_data(cks_word_data), .cks_finish(cks_finish),
    .cks_busy(cks_busy), .cks_done(cks_done), .cks_value(cks_value), .dm_index(dm_index),
    .dm_img_addr(dm_img_addr), .img_omit_cfg(img_omit_cfg), .img_emit_cfg(img_emit_cfg));
  pec_dev_model dev (.icsp_clk(icsp_clk), .icsp_dat_oe(icsp_dat_oe), .host_dat(icsp_dat_o),
    .code_protect_n(dev_prot_n), .dat_out(dev_out), .wr_word(dev_wr));

  // ==========================================================
  // Wire level, clock, shortest clock-low gap over 10 cycles ending in a rise
  assign pin = icsp_dat_oe ? icsp_dat_o : dev_out;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    lowrun <= icsp_clk ? 0 : lowrun + 1;
    if (icsp_clk && lowrun > 10 && lowrun < mingap) mingap <= lowrun;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Request one transfer; dur counts edges from take until ready is back
  task automatic xfer(input logic de, input logic rd, input pec_pkg::pec_wait_t w);
    int i;
    @(posedge clk);
    {req_valid, req_data_en, req_read, req_wait} <= {1'b1, de, rd, w};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    for (dur = 0; dur < 2000; dur++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    if (dur == 2000 || i == 50) begin
      mismatches++;
      summarize();
    end
  endtask

  // Stream words 0..4 and 0x400, then finish; v gets the final value
  task automatic cks_go(input logic p_n, input logic [1:0] sz, input logic w);
    int i;
    @(posedge clk);
    {cks_start, cks_code_protect_n, cks_size, cks_wide_mask} <= {1'b1, p_n, sz, w};
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      cks_start <= 1'b0;
      cks_word_valid <= 1'b1;
      cks_word_addr <= (i == 5) ? 13'h0400 : 13'(i);
    end
    @(posedge clk);
    {cks_word_valid, cks_finish} <= 2'b01;
    chk("busy", 16'h0001, {15'h0000, cks_busy});
    @(posedge clk);
    cks_finish <= 1'b0;
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      if (cks_done === 1'b1) break;
    end
    if (i == 10) begin
      mismatches++;
      summarize();
    end
    v = cks_value;
  endtask

  task automatic t_cks_plain();
    cks_go(1'b1, 2'h0, 1'b0);
    chk("sum_1k", 16'h3FFF * 16'h0005 + 16'h0FFF, v);
    cks_go(1'b1, 2'h1, 1'b1);
    chk("sum_2k", 16'h3FFF * 16'h0006 + 16'h1FFF, v);
    $display("test cks_plain done");
  endtask

  task automatic t_cks_prot();
    cks_go(1'b0, 2'h2, 1'b1);
    chk("sum_prot", 16'h1FFF + 16'h1234, v);
    $display("test cks_prot done");
  endtask

  task automatic t_image();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {dm_index, img_omit_cfg} <= {k[0] ? 8'hFF : 8'h00, k[0]};
      repeat (2) @(posedge clk);
      chk("dm_addr", k[0] ? 16'h21FF : 16'h2100, dm_img_addr);
      chk("emit_cfg", {15'h0000, !k[0]}, {15'h0000, img_emit_cfg});
    end
    $display("test image done");
  endtask

  // Plain read, then read of a protected part; long idle first
  task automatic t_read();
    repeat (200) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      mingap = 1000;
      dev_prot_n <= !k[0];
      xfer(1'b1, 1'b1, pec_pkg::PEC_W_NONE);
      chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
      chk("rdata", k[0] ? 16'h0000 : 16'h2A5C, {2'b00, rsp_rdata});
      chk("gap", 16'h0001, {15'h0000, mingap >= 100 && mingap < 1000});
    end
    $display("test read done");
  endtask

  // First wait follows a write frame of start, payload, stop
  task automatic t_waits();
    int e[4] = '{30, 40, 20, 10};
    for (int k = 0; k < 4; k++) begin
      xfer(k == 0, 1'b0, pec_pkg::pec_wait_t'(k + 1));
      chk("wait", 16'(220 + (k == 0 ? 420 : 0) + e[k]), 16'(dur));
      if (k == 0) chk("wdata", 16'h2AAA, dev_wr);
    end
    $display("test waits done");
  endtask

  initial begin
    {rst, req_valid, req_data_en, req_read, cks_start, cks_word_valid, cks_finish} = 7'h01 << 6;
    {cks_size, cks_wide_mask, cks_code_protect_n, img_omit_cfg, dm_index} = 13'h0;
    req_cmd = 6'h04;
    req_wdata = 14'h1555;
    req_wait = pec_pkg::PEC_W_NONE;
    dev_prot_n = 1'b1;
    cks_cfg = 14'h3FFF;
    {cks_id0, cks_id1, cks_id2, cks_id3} = {14'h3FF1, 14'h0002, 14'h0003, 14'h3FF4};
    cks_word_addr = 13'h0000;
    cks_word_data = 14'h3FFF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_cks_plain();
    t_cks_prot();
    t_image();
    t_read();
    t_waits();
    summarize();
  end
endmodule // pec_host_ctrl_bench

`default_nettype wire
